//--- rtl/asr_map.vh
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// register byte offsets
`define ASR_RCV_CTRL_OFS 8'h00
`define ASR_RX_DATA_OFS 8'h04
`define ASR_TX_CTRL_OFS 8'h08
`define ASR_IRQ_CTRL_OFS 8'h0c

// receive_status_control fields
`define ASR_SERIAL_PORT_ENABLE_BIT 7
`define ASR_NINE_BIT 6
`define ASR_RECEIVE_ENABLE_BIT_BIT 4
`define ASR_FRAME_ERROR_FLAG_BIT 2
`define ASR_OVERRUN_FLAG_BIT 1
`define ASR_RX_NINTH_BIT_BIT 0

// transmit_status_control fields
`define ASR_SYNC_BIT 4

// interrupt control fields
`define ASR_RXIE_BIT 0
`define ASR_PERIPHERAL_IRQ_ENABLE_BIT 1
`define ASR_GIE_BIT 2
`define ASR_PEND_BIT 4

// reset values
`define ASR_RCV_CTRL_RST 8'h00
`define ASR_TX_CTRL_RST 8'h00
`define ASR_IRQ_CTRL_RST 3'h0

// oversampling
`define ASR_OVERSAMPLE 16
`define ASR_HALF_BIT 4'h7
`define ASR_LAST_TICK 4'hf
`define ASR_VOTE_A 4'hd
`define ASR_VOTE_B 4'he
`define ASR_LAST_BIT8 4'h7
`define ASR_LAST_BIT9 4'h8

// receiver states
`define ASR_ST_IDLE 2'h0
`define ASR_ST_START 2'h1
`define ASR_ST_DATA 2'h2
`define ASR_ST_STOP 2'h3

`endif

//--- rtl/asr_rx.v
// How it works
// - line sampled at sixteen ticks per bit
// - finished character moves into two-entry buffer
// - two characters wait while third shifts in
// - falling edge on line starts a character
// - half bit later start must still be low
// - high start centre silently aborts, rearms search
// - each bit centre majority-voted into shift register
// - stop bit low means framing error
// - at stop-bit centre push character, raise pending
// - data read returns and pops oldest character
// - pending follows occupancy while enabled, read-only
// - interrupt needs all three enables set
// - framing status per character, shows oldest
// - framing error never stops reception; pop advances
// - port disable clears framing status, enable doesn't
// - framing error alone raises no interrupt
// - third character with full buffer sets overrun
// - clearing enable or port clears overrun
// - bits assembled least significant first
// - nine-bit mode adds ninth bit per character
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "asr_map.vh"

module asr_rx #(
  parameter DEPTH = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire baud16_tick_i,
  input wire serial_input_pin_i,
  output reg rx_pending_flag_o,
  output reg rx_irq_o,
  output reg rx_idle_o
);

  reg serial_port_enable;
  reg nine_bit_rx_select;
  reg receive_enable_bit;
  reg sync_mode_select;
  reg rx_irq_enable;
  reg peripheral_irq_enable;
  reg global_irq_enable;
  reg overrun_flag;

  reg [1:0] state;
  reg [3:0] tick_cnt;
  reg [3:0] bit_cnt;
  reg [8:0] receive_shift_reg;
  reg vote_a;
  reg vote_b;
  reg line_prev;

  // byte, ninth bit and framing status travel together
  reg [9:0] fifo_mem [0:DEPTH-1];
  reg fifo_wr;
  reg fifo_rd;
  reg [1:0] fifo_cnt;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req = req & wb_we_i & wb_sel_i[0];
  // receiver held idle while off, synchronous or overrun
  wire rx_active = serial_port_enable & receive_enable_bit & ~sync_mode_select & ~overrun_flag;
  wire [9:0] fifo_top = fifo_mem[fifo_rd];
  wire fifo_has = (fifo_cnt != 2'h0);
  wire fifo_full = (fifo_cnt == DEPTH);
  wire pop = req & ~wb_we_i & (wb_adr_i == `ASR_RX_DATA_OFS) & fifo_has;
  wire [3:0] last_bit = nine_bit_rx_select ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8;
  wire centre = baud16_tick_i & (tick_cnt == `ASR_LAST_TICK);
  wire voted;
  wire push;
  wire [9:0] entry;
  wire [7:0] rcv_ctrl_rd;
  wire fifo_we;
  wire hit_rcv;
  wire hit_data;
  wire hit_tx;
  wire hit_irq;
  wire start_edge;
  wire bit_done;
  wire rx_enabled;
  wire next_pending;
  wire next_irq;

  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // address compare shared by the write and read decoders
  function addr_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      addr_hit = (adr == ofs);
    end
  endfunction

  // majority of three samples around centre
  assign voted = maj3(vote_a, vote_b, serial_input_pin_i);

  // character handed over at the stop-bit centre sample
  assign push = rx_active & (state == `ASR_ST_STOP) & centre;
  // lsb first, so an 8-bit character ends in the top bits
  // ninth bit kept in nine-bit mode
  assign entry = nine_bit_rx_select ?
    {~voted, receive_shift_reg[8], receive_shift_reg[7:0]} :
    {~voted, 1'b0, receive_shift_reg[8:1]};

  assign rcv_ctrl_rd = {serial_port_enable, nine_bit_rx_select, 1'b0, receive_enable_bit,
    1'b0, fifo_has & fifo_top[9], overrun_flag, fifo_has & fifo_top[8]};

  assign hit_rcv = addr_hit(wb_adr_i, `ASR_RCV_CTRL_OFS);
  assign hit_data = addr_hit(wb_adr_i, `ASR_RX_DATA_OFS);
  assign hit_tx = addr_hit(wb_adr_i, `ASR_TX_CTRL_OFS);
  assign hit_irq = addr_hit(wb_adr_i, `ASR_IRQ_CTRL_OFS);

  assign start_edge = line_prev & ~serial_input_pin_i;
  assign bit_done = (bit_cnt == last_bit);

  // popped slot takes the new character
  assign fifo_we = push & (~fifo_full | pop);

  // pending and request low while reception is off
  assign rx_enabled = serial_port_enable & receive_enable_bit;
  assign next_pending = rx_enabled & fifo_has;
  assign next_irq = next_pending & rx_irq_enable & peripheral_irq_enable & global_irq_enable;

  // control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_port_enable <= 1'b0;
      nine_bit_rx_select <= 1'b0;
      receive_enable_bit <= 1'b0;
      sync_mode_select <= 1'b0;
      rx_irq_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (wr_req) begin
      if (hit_rcv) begin
        serial_port_enable <= wb_dat_i[`ASR_SERIAL_PORT_ENABLE_BIT];
        nine_bit_rx_select <= wb_dat_i[`ASR_NINE_BIT];
        receive_enable_bit <= wb_dat_i[`ASR_RECEIVE_ENABLE_BIT_BIT];
      end else if (hit_tx) begin
        sync_mode_select <= wb_dat_i[`ASR_SYNC_BIT];
      end else if (hit_irq) begin
        rx_irq_enable <= wb_dat_i[`ASR_RXIE_BIT];
        peripheral_irq_enable <= wb_dat_i[`ASR_PERIPHERAL_IRQ_ENABLE_BIT];
        global_irq_enable <= wb_dat_i[`ASR_GIE_BIT];
      end
    end
  end

  // bus answer, one cycle after the request
  // empty or unmapped reads give zero, writes still acked
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        if (hit_rcv) begin
          wb_dat_o <= {24'h0, rcv_ctrl_rd};
        end else if (hit_data) begin
          // oldest character; empty buffer reads zero
          wb_dat_o <= {24'h0, fifo_has ? fifo_top[7:0] : 8'h00};
        end else if (hit_tx) begin
          wb_dat_o <= {27'h0, sync_mode_select, 4'h0};
        end else if (hit_irq) begin
          wb_dat_o <= {27'h0, rx_pending_flag_o, 1'b0, global_irq_enable,
            peripheral_irq_enable, rx_irq_enable};
        end else begin
          wb_dat_o <= 32'h0;
        end
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // receive sequencer
  // leaving the active state drops a half-received character
  always @(posedge clk_i) begin
    if (rst_i | ~rx_active) begin
      state <= `ASR_ST_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      receive_shift_reg <= 9'h0;
      vote_a <= 1'b1;
      vote_b <= 1'b1;
      line_prev <= 1'b1;
    end else if (baud16_tick_i) begin
      // every decision runs on the 16x tick
      line_prev <= serial_input_pin_i;
      tick_cnt <= tick_cnt + 4'h1;
      if (tick_cnt == `ASR_VOTE_A) begin
        vote_a <= serial_input_pin_i;
      end
      if (tick_cnt == `ASR_VOTE_B) begin
        vote_b <= serial_input_pin_i;
      end
      case (state)
        `ASR_ST_IDLE: begin
          tick_cnt <= 4'h0;
          if (start_edge) begin
            state <= `ASR_ST_START;
          end
        end
        `ASR_ST_START: begin
          // check the line at start-bit centre
          if (tick_cnt == `ASR_HALF_BIT) begin
            tick_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            if (serial_input_pin_i) begin
              state <= `ASR_ST_IDLE;
            end else begin
              state <= `ASR_ST_DATA;
            end
          end
        end
        `ASR_ST_DATA: begin
          if (tick_cnt == `ASR_LAST_TICK) begin
            // one full bit to each centre
            receive_shift_reg <= {voted, receive_shift_reg[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_done) begin
              state <= `ASR_ST_STOP;
            end
          end
        end
        default: begin
          // a framing error just rearms the search
          if (tick_cnt == `ASR_LAST_TICK) begin
            state <= `ASR_ST_IDLE;
          end
        end
      endcase
    end
  end

  // two-entry buffer
  always @(posedge clk_i) begin
    if (rst_i | ~serial_port_enable) begin
      // port disable flushes entries and framing status
      fifo_wr <= 1'b0;
      fifo_rd <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      // entries kept while the next character shifts in
      if (fifo_we) begin
        fifo_wr <= ~fifo_wr;
      end
      // pop advances to the next status
      if (pop) begin
        fifo_rd <= ~fifo_rd;
      end
      // push and pop together leave the count alone
      case ({fifo_we, pop})
        2'h2: begin
          fifo_cnt <= fifo_cnt + 2'h1;
        end
        2'h1: begin
          fifo_cnt <= fifo_cnt - 2'h1;
        end
        default: begin
          fifo_cnt <= fifo_cnt;
        end
      endcase
    end
  end

  // entry stored as one word
  // no reset on the array: only read behind fifo_has
  always @(posedge clk_i) begin
    if (fifo_we) begin
      fifo_mem[fifo_wr] <= entry;
    end
  end

  // overrun: set wins over a same-cycle clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      overrun_flag <= 1'b0;
    end else if (push & fifo_full & ~pop) begin
      overrun_flag <= 1'b1;
    end else if (~receive_enable_bit | ~serial_port_enable) begin
      overrun_flag <= 1'b0;
    end
  end

  // pending rises once the character is stored
  // follows occupancy, bus writes cannot touch it
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_pending_flag_o <= 1'b0;
    end else begin
      rx_pending_flag_o <= next_pending;
    end
  end

  // request gated by all three enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= next_irq;
    end
  end

  // idle output lags the sequencer by one clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_idle_o <= 1'b1;
    end else begin
      rx_idle_o <= (state == `ASR_ST_IDLE);
    end
  end

endmodule // asr_rx

//--- dv/asr_rx_properties.sv
`timescale 1ns/100ps
module asr_rx_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire serial_input_pin_i,
  input wire rx_pending_flag_o,
  input wire rx_irq_o,
  input wire rx_idle_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  reset_state_a: assert property ($past(rst_i) |-> rx_idle_o && !rx_pending_flag_o && !rx_irq_o)
    else $error("state after reset wrong");
  irq_needs_pending_a: assert property (rx_irq_o |-> rx_pending_flag_o || $past(rx_pending_flag_o))
    else $error("interrupt without pending data");
  idle_hold_a: assert property ((rx_idle_o && serial_input_pin_i) [*8] |=> rx_idle_o)
    else $error("receiver left idle without falling edge");
  pend_cause_a: assert property ($fell(rx_pending_flag_o) |-> $past(wb_stb_i) || $past(wb_stb_i, 2))
    else $error("pending dropped without bus access");
  pend_rise_a: assert property ($rose(rx_pending_flag_o) |-> rx_idle_o)
    else $error("pending rose before character finished");
endmodule // asr_rx_properties

bind asr_rx asr_rx_properties i_asr_rx_properties (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_input_pin_i(serial_input_pin_i), .rx_pending_flag_o(rx_pending_flag_o),
  .rx_irq_o(rx_irq_o), .rx_idle_o(rx_idle_o));

//--- dv/asr_tx_model.sv
`timescale 1ns/100ps
module asr_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      line_o <= d[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= stop;
    repeat (BIT_CLKS) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask
  // short low pulse: gone before start centre
  task automatic glitch();
    line_o <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_i);
  endtask
endmodule // asr_tx_model

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_i, rst_i, cyc, stb, we;
  logic tick = 1'b0;
  logic [7:0] adr, rd;
  logic [31:0] wdat;
  wire [31:0] dat_o;
  wire ack, pend, irq, idle, line;
  int n_errors = 0;
  int num_checks = 0;
  asr_rx i_asr_rx (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .baud16_tick_i(tick), .serial_input_pin_i(line),
    .rx_pending_flag_o(pend), .rx_irq_o(irq), .rx_idle_o(idle));
  asr_tx_model i_asr_tx_model (.clk_i(clk_i), .line_o(line));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // tick every second clock: 32 clocks per bit
  always @(posedge clk_i) tick <= !tick;
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      end_sim();
    end
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  initial begin
    {cyc, stb, we, adr, wdat, rd} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h00, 8'h00);
    rdc(8'h0c, 8'h00);
    rdc(8'h10, 8'h00);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h0c, 8'h07);
    bus(1'b1, 8'h00, 8'h90);
    rdc(8'h00, 8'h90);
    i_asr_tx_model.send(9'h0a5, 8, 1'b1);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, idle}, 8'h01);
    bus(1'b1, 8'h0c, 8'h07);
    rdc(8'h0c, 8'h17);
    rdc(8'h04, 8'ha5);
    chk({7'h0, pend}, 8'h00);
    bus(1'b1, 8'h0c, 8'h17);
    rdc(8'h0c, 8'h07);
    i_asr_tx_model.glitch();
    chk({7'h0, pend}, 8'h00);
    i_asr_tx_model.send(9'h03c, 8, 1'b0);
    i_asr_tx_model.send(9'h05a, 8, 1'b1);
    rdc(8'h00, 8'h94);
    rdc(8'h04, 8'h3c);
    rdc(8'h00, 8'h90);
    rdc(8'h04, 8'h5a);
    i_asr_tx_model.send(9'h011, 8, 1'b1);
    i_asr_tx_model.send(9'h022, 8, 1'b1);
    i_asr_tx_model.send(9'h033, 8, 1'b1);
    rdc(8'h00, 8'h92);
    i_asr_tx_model.send(9'h044, 8, 1'b1);
    rdc(8'h04, 8'h11);
    rdc(8'h04, 8'h22);
    rdc(8'h04, 8'h00);
    bus(1'b1, 8'h00, 8'h80);
    rdc(8'h00, 8'h80);
    bus(1'b1, 8'h0c, 8'h03);
    bus(1'b1, 8'h00, 8'hd0);
    i_asr_tx_model.send(9'h1c3, 9, 1'b1);
    chk({6'h0, pend, irq}, 8'h02);
    rdc(8'h00, 8'hd1);
    rdc(8'h04, 8'hc3);
    i_asr_tx_model.send(9'h0f0, 9, 1'b0);
    bus(1'b1, 8'h00, 8'hc0);
    rdc(8'h00, 8'hc4);
    bus(1'b1, 8'h00, 8'h00);
    rdc(8'h00, 8'h00);
    end_sim();
  end
endmodule // tb
